//--- rtl/tsr_params.svh
// Offsets, field positions, reset values and counts of the TDM slot router.
// Assumes byte addresses on an 8-bit register port with 32-bit data.
`ifndef TSR_PARAMS_SVH
`define TSR_PARAMS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define TSR_OFF_PATH 8'h00
`define TSR_OFF_MASK_A_LO 8'h04
`define TSR_OFF_MASK_A_HI 8'h08
`define TSR_OFF_MASK_B_LO 8'h0C
`define TSR_OFF_MASK_B_HI 8'h10
`define TSR_OFF_STATUS 8'h14

// ************************************************************
// Field positions and codes
// ************************************************************
`define TSR_PATH_AUD_LSB 0
`define TSR_PATH_LL_LSB 3
`define TSR_PATH_REF_LSB 6
`define TSR_PATH_PCM_BIT 9
`define TSR_REF_MASKED 3'h4
`define TSR_STAT_OVF_BIT 0

// ************************************************************
// Reset values and counts
// ************************************************************
`define TSR_PATH_RESET 10'h000
`define TSR_MASK_RESET 8'hFF
`define TSR_SLOT_LAST_BIT 5'h1F
`define TSR_TDM_LAST_SLOT 4'hF
`define TSR_PCM_LAST_SLOT 4'h1

`endif

//--- rtl/tsr_pkg.sv
// Types shared by the TDM slot router and its testbench.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package tsr_pkg;
  typedef logic [23:0] tsr_sample_t;
  typedef logic [2:0] tsr_sel_t;
  // One captured frame: four audio, four low-latency, one reference
  typedef struct packed {
    logic [3:0][23:0] audio;
    logic [3:0][23:0] low_latency;
    logic [23:0] reference;
  } tsr_frame_t;
endpackage
`default_nettype wire

//--- rtl/tsr_stream_if.sv
// Valid/ready stream carrying one word between router modules.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface tsr_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

//--- rtl/tsr_pair_buffer.sv
// Two-entry valid/ready buffer; head entry drives the output directly.
// Assumes a synchronous active-low reset on the same clock.
`timescale 1ns/1ps
`default_nettype none
module tsr_pair_buffer #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  tsr_stream_if.snk in_s,
  tsr_stream_if.src out_s
);
  logic [W-1:0] e0_q;
  logic [W-1:0] e1_q;
  logic v0_q;
  logic v1_q;
  wire logic push;
  wire logic pop;

  // Full only when the second entry holds a word
  assign in_s.ready = ~v1_q;
  assign push = in_s.valid & ~v1_q;
  assign pop = v0_q & out_s.ready;
  assign out_s.valid = v0_q;
  assign out_s.data = e0_q;

  // Head shifts forward on pop; push fills the first free entry
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      v0_q <= 1'b0;
      v1_q <= 1'b0;
      e0_q <= '0;
      e1_q <= '0;
    end else if (pop) begin
      e0_q <= push ? in_s.data : e1_q;
      v0_q <= v1_q | push;
      v1_q <= 1'b0;
    end else if (push) begin
      if (v0_q) begin
        e1_q <= in_s.data;
        v1_q <= 1'b1;
      end else begin
        e0_q <= in_s.data;
        v0_q <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/tsr_router.sv
// TDM slot router: receives two serial lines, picks slots for the audio,
// low-latency and reference paths, and hands out one record per frame.
// Assumes bit clock, frame sync and data pins are asynchronous to clk,
// with the bit clock well below a quarter of the clk rate.
`timescale 1ns/1ps
`default_nettype none
`include "tsr_params.svh"

module tsr_router (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic bit_clock,
  input wire logic frame_sync,
  input wire logic serial_input_a,
  input wire logic serial_input_b,
  output logic frame_valid,
  input wire logic frame_ready,
  output logic [95:0] frame_audio,
  output logic [95:0] frame_low_latency,
  output logic [23:0] frame_reference
);
  // ************************************************************
  // Pin synchronisers and bit clock edge
  // ************************************************************
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic sclk_prev_q;
  logic fs_prev_q;

  // Two flops per pin; only s2 is looked at
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      sclk_prev_q <= 1'b0;
    end else begin
      s1_q <= {serial_input_b, serial_input_a, frame_sync, bit_clock};
      s2_q <= s1_q;
      sclk_prev_q <= s2_q[0];
    end
  end

  wire logic sclk_rise = s2_q[0] & ~sclk_prev_q;
  wire logic fs_s = s2_q[1];
  wire logic din_a = s2_q[2];
  wire logic din_b = s2_q[3];
  wire logic frame_start = sclk_rise & fs_s & ~fs_prev_q;

  // ************************************************************
  // Registers
  // ************************************************************
  logic [9:0] path_q;
  logic [7:0] mask_a_lo_q;
  logic [7:0] mask_a_hi_q;
  logic [7:0] mask_b_lo_q;
  logic [7:0] mask_b_hi_q;
  logic ovf_q;
  logic ovf_d;
  logic [31:0] rdata_d;

  wire logic [2:0] aud_sel = path_q[`TSR_PATH_AUD_LSB +: 3];
  wire logic [2:0] ll_sel = path_q[`TSR_PATH_LL_LSB +: 3];
  wire logic [2:0] ref_sel = path_q[`TSR_PATH_REF_LSB +: 3];
  wire logic pcm_mode = path_q[`TSR_PATH_PCM_BIT];
  wire logic wr_path = reg_write & (reg_addr == `TSR_OFF_PATH);
  wire logic wr_stat = reg_write & (reg_addr == `TSR_OFF_STATUS);

  // Software steers masks and selects; masked by default after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      path_q <= `TSR_PATH_RESET;
      mask_a_lo_q <= `TSR_MASK_RESET;
      mask_a_hi_q <= `TSR_MASK_RESET;
      mask_b_lo_q <= `TSR_MASK_RESET;
      mask_b_hi_q <= `TSR_MASK_RESET;
    end else if (reg_write) begin
      if (wr_path) path_q <= reg_wdata[9:0];
      if (reg_addr == `TSR_OFF_MASK_A_LO) mask_a_lo_q <= reg_wdata[7:0];
      if (reg_addr == `TSR_OFF_MASK_A_HI) mask_a_hi_q <= reg_wdata[7:0];
      if (reg_addr == `TSR_OFF_MASK_B_LO) mask_b_lo_q <= reg_wdata[7:0];
      if (reg_addr == `TSR_OFF_MASK_B_HI) mask_b_hi_q <= reg_wdata[7:0];
    end
  end

  // ************************************************************
  // Mask decode and priority pick
  // ************************************************************
  wire logic [31:0] unmask;
  genvar k;
  // Slot k of a group sits at bit 7-k; zero bit admits the slot
  generate
    for (k = 0; k < 8; k++) begin : g_unmask
      assign unmask[k] = ~mask_a_lo_q[7-k];
      assign unmask[k+8] = ~mask_a_hi_q[7-k];
      assign unmask[k+16] = ~mask_b_lo_q[7-k];
      assign unmask[k+24] = ~mask_b_hi_q[7-k];
    end
  endgenerate

  // Scans downward so the lowest unmasked index is left standing
  function automatic logic [4:0] pick_first(input logic [31:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) idx = 5'(i);
    end
    return idx;
  endfunction

  wire logic [4:0] sel_idx = pick_first(unmask);
  wire logic any_unmasked = |unmask;

  // ************************************************************
  // Slot receiver
  // ************************************************************
  logic [31:0] sh_a_q;
  logic [31:0] sh_b_q;
  logic [4:0] bit_q;
  logic [3:0] slot_q;
  logic in_frame_q;

  wire logic bit_on = sclk_rise & (in_frame_q | frame_start);
  wire logic [4:0] bit_now = frame_start ? 5'h00 : bit_q;
  wire logic [3:0] slot_now = frame_start ? 4'h0 : slot_q;
  wire logic word_done = bit_on & (bit_now == `TSR_SLOT_LAST_BIT);
  wire logic [31:0] word_a = {sh_a_q[30:0], din_a};
  wire logic [31:0] word_b = {sh_b_q[30:0], din_b};
  wire logic [3:0] last_slot =
    pcm_mode ? `TSR_PCM_LAST_SLOT : `TSR_TDM_LAST_SLOT;
  wire logic frame_end = word_done & (slot_now == last_slot);

  // MSB first from the edge that sees frame sync rise; 32 bits a slot
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sh_a_q <= '0;
      sh_b_q <= '0;
      bit_q <= 5'h00;
      slot_q <= 4'h0;
      in_frame_q <= 1'b0;
      fs_prev_q <= 1'b0;
    end else if (sclk_rise) begin
      fs_prev_q <= fs_s;
      if (bit_on) begin
        sh_a_q <= word_a;
        sh_b_q <= word_b;
        bit_q <= bit_now + 5'h01;
        slot_q <= word_done ? slot_now + 4'h1 : slot_now;
        in_frame_q <= ~frame_end;
      end
    end
  end

  // ************************************************************
  // Path capture
  // ************************************************************
  logic [3:0][23:0] aud_q;
  logic [3:0][23:0] ll_q;
  logic [23:0] ref_q;

  wire logic [23:0] aud_word = aud_sel[2] ? word_b[31:8] : word_a[31:8];
  wire logic [23:0] ll_word = ll_sel[2] ? word_b[31:8] : word_a[31:8];
  wire logic [23:0] msk_word = sel_idx[4] ? word_b[31:8] : word_a[31:8];
  wire logic aud_hit = word_done & ~pcm_mode &
    (slot_now[3:2] == aud_sel[1:0]);
  wire logic ll_hit = word_done & ~pcm_mode &
    (slot_now[3:2] == ll_sel[1:0]);
  wire logic ref_code_hit = word_done & ~pcm_mode & ~ref_sel[2] &
    (slot_now[3:2] == ref_sel[1:0]) & (slot_now[1:0] != 2'h3);
  wire logic ref_mask_hit = word_done & ~pcm_mode &
    (ref_sel == `TSR_REF_MASKED) & any_unmasked &
    (slot_now == sel_idx[3:0]);
  wire logic pcm_hit = word_done & pcm_mode;

  // Cleared at frame start so unselected or masked paths read zero
  always_ff @(posedge clk) begin
    if (!rst_n || frame_start) begin
      aud_q <= '0;
      ll_q <= '0;
      ref_q <= '0;
    end else if (word_done) begin
      if (aud_hit) aud_q[slot_now[1:0]] <= aud_word;
      if (ll_hit) ll_q[slot_now[1:0]] <= ll_word;
      // Slot bytes go high to low, sample slots never touch them
      if (ref_code_hit) begin
        ref_q[5'(16 - 8 * slot_now[1:0]) +: 8] <= word_a[7:0];
      end
      if (ref_mask_hit) ref_q <= msk_word;
      // Two-channel formats: line A to ch1-2, line B to ch3-4
      if (pcm_hit) begin
        aud_q[{1'b0, slot_now[0]}] <= word_a[31:8];
        aud_q[{1'b1, slot_now[0]}] <= word_b[31:8];
        ll_q[{1'b0, slot_now[0]}] <= word_a[31:8];
        ll_q[{1'b1, slot_now[0]}] <= word_b[31:8];
      end
    end
  end

  // ************************************************************
  // Frame hand-off
  // ************************************************************
  tsr_pkg::tsr_frame_t rec_q;
  tsr_pkg::tsr_frame_t cur_frame;
  logic pend_q;
  tsr_stream_if #(.W($bits(tsr_pkg::tsr_frame_t))) in_st ();
  tsr_stream_if #(.W($bits(tsr_pkg::tsr_frame_t))) out_st ();

  assign cur_frame.audio = aud_q;
  assign cur_frame.low_latency = ll_q;
  assign cur_frame.reference = ref_q;
  assign in_st.valid = pend_q;
  assign in_st.data = rec_q;
  assign out_st.ready = frame_ready;

  // The last slot lands in the capture flops one cycle after frame_end
  logic end_seen_q;
  wire logic take = pend_q & in_st.ready;

  // Record waits while the buffer is full; a newer frame then is lost
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      end_seen_q <= 1'b0;
      pend_q <= 1'b0;
      rec_q <= '0;
    end else begin
      end_seen_q <= frame_end;
      if (end_seen_q && (!pend_q || take)) begin
        rec_q <= cur_frame;
        pend_q <= 1'b1;
      end else if (take) begin
        pend_q <= 1'b0;
      end
    end
  end

  tsr_pair_buffer #(.W($bits(tsr_pkg::tsr_frame_t))) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_s(in_st),
    .out_s(out_st)
  );

  tsr_pkg::tsr_frame_t head;
  assign head = out_st.data;
  assign frame_valid = out_st.valid;
  assign frame_audio = head.audio;
  assign frame_low_latency = head.low_latency;
  assign frame_reference = head.reference;

  // ************************************************************
  // Status and read port
  // ************************************************************
  wire logic lost = end_seen_q & pend_q & ~take;
  wire logic [31:0] status = {20'h00000, pend_q, slot_q, any_unmasked,
    sel_idx, ovf_q};

  // Loss flag: write one clears, a loss in the same cycle wins
  assign ovf_d = lost | (ovf_q & ~(wr_stat & reg_wdata[`TSR_STAT_OVF_BIT]));

  always_comb begin
    rdata_d = 32'h00000000;
    unique case (reg_addr)
      `TSR_OFF_PATH: rdata_d = {22'h000000, path_q};
      `TSR_OFF_MASK_A_LO: rdata_d = {24'h000000, mask_a_lo_q};
      `TSR_OFF_MASK_A_HI: rdata_d = {24'h000000, mask_a_hi_q};
      `TSR_OFF_MASK_B_LO: rdata_d = {24'h000000, mask_b_lo_q};
      `TSR_OFF_MASK_B_HI: rdata_d = {24'h000000, mask_b_hi_q};
      `TSR_OFF_STATUS: rdata_d = status;
      default: rdata_d = 32'h00000000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ovf_q <= 1'b0;
      reg_rdata <= 32'h00000000;
    end else begin
      ovf_q <= ovf_d;
      reg_rdata <= reg_read ? rdata_d : 32'h00000000;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_aud_capture;
    @(posedge clk) disable iff (!rst_n)
      aud_hit |=> aud_q[$past(slot_now[1:0])] == $past(aud_word);
  endproperty
  a_aud_capture: assert property (p_aud_capture)
    else $error("audio slot not captured");

  property p_ll_line;
    @(posedge clk) disable iff (!rst_n)
      (ll_hit && ll_sel[2]) |=> ll_q[$past(slot_now[1:0])] ==
        $past(word_b[31:8]);
  endproperty
  a_ll_line: assert property (p_ll_line)
    else $error("low latency not from line b");

  property p_ref_bytes;
    @(posedge clk) disable iff (!rst_n)
      (ref_code_hit && slot_now[1:0] == 2'h0) |=>
        ref_q[23:16] == $past(word_a[7:0]);
  endproperty
  a_ref_bytes: assert property (p_ref_bytes)
    else $error("reference high byte wrong");

  property p_mask_pick;
    @(posedge clk) disable iff (!rst_n)
      ref_mask_hit |=> ref_q == $past(msk_word);
  endproperty
  a_mask_pick: assert property (p_mask_pick)
    else $error("masked reference not taken");

  property p_mask_polarity;
    @(posedge clk) disable iff (!rst_n)
      unmask[0] == ~mask_a_lo_q[7] && unmask[15] == ~mask_a_hi_q[0] &&
      unmask[16] == ~mask_b_lo_q[7];
  endproperty
  a_mask_polarity: assert property (p_mask_polarity)
    else $error("mask bit mapping wrong");

  property p_priority;
    @(posedge clk) disable iff (!rst_n)
      any_unmasked |-> unmask[sel_idx] &&
        ((unmask & ((32'h00000001 << sel_idx) - 32'h00000001)) == '0);
  endproperty
  a_priority: assert property (p_priority)
    else $error("priority pick wrong");

  property p_all_masked;
    @(posedge clk) disable iff (!rst_n)
      (end_seen_q && ref_sel == `TSR_REF_MASKED && !any_unmasked &&
        $stable(path_q) && !$past(any_unmasked, 2) &&
        (!pend_q || take)) |=> rec_q.reference == 24'h000000;
  endproperty
  a_all_masked: assert property (p_all_masked)
    else $error("all masked but reference nonzero");

  property p_pcm_ref;
    @(posedge clk) disable iff (!rst_n)
      (pcm_mode && word_done) |=> ref_q == $past(ref_q) ||
        ref_q == 24'h000000;
  endproperty
  a_pcm_ref: assert property (p_pcm_ref)
    else $error("reference written in pcm format");

  property p_slot_len;
    @(posedge clk) disable iff (!rst_n)
      word_done |=> bit_q == 5'h00;
  endproperty
  a_slot_len: assert property (p_slot_len)
    else $error("slot not 32 bits");

  property p_read_once;
    @(posedge clk) disable iff (!rst_n)
      (reg_read && reg_addr == `TSR_OFF_PATH) |=>
        reg_rdata == {22'h000000, $past(path_q)};
  endproperty
  a_read_once: assert property (p_read_once)
    else $error("read data wrong");
endmodule
`default_nettype wire

//--- dv/tsr_tdm_source.sv
// Far-side model: a TDM source driving bit clock, frame sync, two lines.
// Assumes the router samples data on the bit clock rise, MSB first.
`timescale 1ns/1ps
`default_nettype none
module tsr_tdm_source (
  output logic bit_clock,
  output logic frame_sync,
  output logic serial_input_a,
  output logic serial_input_b
);
  // ************************************************************
  // Idle state
  // ************************************************************
  // Clock stands still between frames
  initial begin
    bit_clock = 1'b0;
    frame_sync = 1'b0;
    serial_input_a = 1'b0;
    serial_input_b = 1'b0;
  end

  // ************************************************************
  // Frame sender
  // ************************************************************
  // Data change on the falling half so the rise sees settled bits
  task automatic send(input logic [15:0][31:0] a,
                      input logic [15:0][31:0] b, input int nslots);
    for (int s = 0; s < nslots; s++) begin
      for (int i = 31; i >= 0; i--) begin
        frame_sync = (s == 0) && (i == 31);
        serial_input_a = a[s][i];
        serial_input_b = b[s][i];
        #80;
        bit_clock = 1'b1;
        #80;
        bit_clock = 1'b0;
      end
    end
    // Released lines flip, so a stale last bit is never mistaken for data
    serial_input_a = ~serial_input_a;
    serial_input_b = ~serial_input_b;
  endtask
endmodule
`default_nettype wire

//--- dv/tsr_router_tb_top.sv
// Self-checking bench of the TDM slot router: registers, frames, buffer.
// Assumes the router package, header and partner model compile first.
`timescale 1ns/1ps
`default_nettype none
`include "tsr_params.svh"
module tsr_router_tb_top;
  logic clk, rst_n, reg_write, reg_read, frame_ready, rd_pend;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, seed, w;
  logic frame_valid, bit_clock, frame_sync, serial_input_a, serial_input_b;
  logic [95:0] frame_audio, frame_low_latency;
  logic [23:0] frame_reference;
  logic [15:0][31:0] sa, sb;
  logic [63:0] rtmp;
  logic [29:0] p;
  tsr_pkg::tsr_frame_t ftmp;
  tsr_pkg::tsr_frame_t fq[$];
  logic [63:0] rq[$];
  int errors, checked;

  tsr_router dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .bit_clock(bit_clock), .frame_sync(frame_sync),
    .serial_input_a(serial_input_a), .serial_input_b(serial_input_b),
    .frame_valid(frame_valid), .frame_ready(frame_ready),
    .frame_audio(frame_audio), .frame_low_latency(frame_low_latency),
    .frame_reference(frame_reference));
  tsr_tdm_source u_src (.bit_clock(bit_clock), .frame_sync(frame_sync),
    .serial_input_a(serial_input_a), .serial_input_b(serial_input_b));

  // ************************************************************
  // Clock, helpers and report
  // ************************************************************
  // 250 MHz system clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Xorshift keeps runs repeatable
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Counts: %0d compared, %0d mismatched", checked, errors);
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Four slots of a group code, channel one in the low bits
  function automatic logic [95:0] grp(input logic [2:0] c);
    logic [95:0] r;
    for (int n = 0; n < 4; n++) begin
      r[n*24 +: 24] = c[2] ? sb[c[1:0]*4+n][31:8] : sa[c[1:0]*4+n][31:8];
    end
    return r;
  endfunction

  // Lowest unmasked slot wins; result is index, found flag, sample
  function automatic logic [29:0] pick(input logic [31:0] m);
    logic [29:0] r;
    r = 30'h0;
    for (int k = 31; k >= 0; k--) begin
      if (!m[(k/8)*8 + 7 - k%8]) begin
        r = {5'(k), 1'b1, k < 16 ? sa[k][31:8] : sb[k-16][31:8]};
      end
    end
    return r;
  endfunction

  task automatic fill();
    for (int s = 0; s < 16; s++) begin
      sa[s] = xs();
      sb[s] = xs();
    end
  endtask

  // One-cycle strobes, separated by an idle edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    rq.push_back({e & m, m});
    @(posedge clk);
    reg_read <= 1'b0;
  endtask

  task automatic masks(input logic [31:0] v);
    for (int i = 0; i < 4; i++) wr(8'(4 + 4*i), {24'h0, v[8*i +: 8]});
  endtask

  // Bounded wait for every noted frame to come out
  task automatic drain();
    for (int i = 0; i < 400 && fq.size() != 0; i++) @(posedge clk);
    if (fq.size() != 0) begin
      errors++;
      $display("[FAIL] %0t frames missing", $time);
      report_and_stop();
    end
  endtask

  // ************************************************************
  // Output monitor
  // ************************************************************
  // Read data stand the cycle after the strobe; frames pop on handshake
  always @(posedge clk) begin
    rd_pend <= reg_read;
    if (rd_pend) begin
      rtmp = rq.pop_front();
      check({64'h0, reg_rdata & rtmp[31:0]}, {64'h0, rtmp[63:32]});
    end
    if (frame_valid === 1'b1 && frame_ready === 1'b1) begin
      if (fq.size() == 0) begin
        errors++;
        $display("[FAIL] %0t unexpected frame", $time);
      end else begin
        ftmp = fq.pop_front();
        check(frame_audio, ftmp.audio);
        check(frame_low_latency, ftmp.low_latency);
        check({72'h0, frame_reference}, {72'h0, ftmp.reference});
      end
    end
  end

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    rst_n = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    frame_ready = 1'b1;
    seed = 32'h00000032;
    errors = 0;
    checked = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // Reset values, then an unmapped place reads zero
    rd(`TSR_OFF_PATH, 32'h0, 32'hFFFFFFFF);
    for (int i = 1; i < 5; i++) rd(8'(4*i), 32'hFF, 32'hFFFFFFFF);
    rd(8'h18, 32'h0, 32'hFFFFFFFF);
    $display("Test registers done");
    // Groups B5-8 and A9-12, reference bytes from A slots 5-7
    fill();
    wr(`TSR_OFF_PATH, 32'h00000055);
    fq.push_back({grp(3'h5), grp(3'h2), sa[4][7:0], sa[5][7:0],
                  sa[6][7:0]});
    u_src.send(sa, sb, 16);
    drain();
    $display("Test slot groups done");
    // Random masks decide the reference slot, lowest slot first
    fill();
    w = xs();
    masks(w);
    wr(`TSR_OFF_PATH, 32'h00000138);
    p = pick(w);
    fq.push_back({grp(3'h0), grp(3'h7), p[23:0]});
    u_src.send(sa, sb, 16);
    drain();
    for (int i = 0; i < 4; i++) begin
      rd(8'(4 + 4*i), {24'h0, w[8*i +: 8]}, 32'hFFFFFFFF);
    end
    rd(`TSR_OFF_STATUS, {25'h0, p[24], p[29:25], 1'b0}, 32'h7E);
    $display("Test mask selection done");
    // Every slot masked gives a zero reference
    fill();
    masks(32'hFFFFFFFF);
    wr(`TSR_OFF_PATH, 32'h00000123);
    fq.push_back({grp(3'h3), grp(3'h4), 24'h0});
    u_src.send(sa, sb, 16);
    drain();
    $display("Test all masked done");
    // Reserved reference code keeps the path at zero despite open masks
    fill();
    masks(xs());
    wr(`TSR_OFF_PATH, 32'h00000171);
    fq.push_back({grp(3'h1), grp(3'h6), 24'h0});
    u_src.send(sa, sb, 16);
    drain();
    $display("Test reserved code done");
    // Two-slot frames with the sink stalled: three kept, fourth lost
    wr(`TSR_OFF_PATH, 32'h00000200);
    @(posedge clk);
    frame_ready <= 1'b0;
    for (int f = 0; f < 4; f++) begin
      fill();
      if (f < 3) begin
        fq.push_back({sb[1][31:8], sb[0][31:8], sa[1][31:8], sa[0][31:8],
                      sb[1][31:8], sb[0][31:8], sa[1][31:8], sa[0][31:8],
                      24'h0});
      end
      u_src.send(sa, sb, 2);
    end
    repeat (20) @(posedge clk);
    rd(`TSR_OFF_STATUS, 32'h801, 32'h801);
    wr(`TSR_OFF_STATUS, 32'h1);
    rd(`TSR_OFF_STATUS, 32'h800, 32'h801);
    @(posedge clk);
    frame_ready <= 1'b1;
    drain();
    repeat (3) @(posedge clk);
    check({95'h0, frame_valid}, 96'h0);
    rd(`TSR_OFF_STATUS, 32'h0, 32'h801);
    repeat (3) @(posedge clk);
    $display("Test buffer stall done");
    report_and_stop();
  end
endmodule
`default_nettype wire
